// File: rtl/obfs_pkg.sv
package obfs_pkg;
  // ************************************************
  // Timing
  // ************************************************
  localparam int CLK_PERIOD_NS   = 8;        // 125 MHz
  localparam int CLK_KHZ         = 125000;
  localparam int FAULT_PULSE_NS  = 128000;   // Fault pulse width
  localparam int FAULT_PULSE_CYC = (FAULT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SOFTSTART_MS    = 8;        // Pre-charge window
  localparam int SOFTSTART_CYC   = SOFTSTART_MS * 1000000 / CLK_PERIOD_NS;
  localparam int OVERLOAD_MS     = 8;        // Current limit window
  localparam int OVERLOAD_CYC    = OVERLOAD_MS * 1000000 / CLK_PERIOD_NS;
  localparam longint WATCHDOG_S  = 30;       // Host watchdog
  localparam longint WATCHDOG_CYC = WATCHDOG_S * 64'd1000000000 / CLK_PERIOD_NS;
  localparam int OVP_DEGLITCH_US = 1;        // Output overvoltage deglitch
  localparam int OVP_DEGLITCH_CYC = OVP_DEGLITCH_US * 1000 / CLK_PERIOD_NS;
  localparam int BOOST_SW_KHZ    = 1500;     // Boost switching rate
  localparam int BOOST_SW_DIV    = CLK_KHZ / BOOST_SW_KHZ;
  localparam int CNT_W           = 32;
  // ************************************************
  // Reset values and codes
  // ************************************************
  localparam logic       BOOST_REQ_RST = 1'b0;
  localparam logic [1:0] ST_READY = 2'h0;
  localparam logic [1:0] ST_CHG   = 2'h1;
  localparam logic [1:0] ST_DONE  = 2'h2;
  localparam logic [1:0] ST_FAULT = 2'h3;
  localparam logic [2:0] FLT_NONE     = 3'h0;
  localparam logic [2:0] FLT_BST_OVP  = 3'h1;
  localparam logic [2:0] FLT_LOW_SUP  = 3'h2;
  localparam logic [2:0] FLT_THERMAL  = 3'h3;
  localparam logic [2:0] FLT_BST_OC   = 3'h4;
  // Boost mode states
  typedef enum logic [3:0] {
    BST_IDLE   = 4'h1,
    BST_PRECHG = 4'h2,
    BST_SWITCH = 4'h4,
    BST_BURST  = 4'h8
  } obfs_boost_t;
  // Saturating up-count step for the hold timers
  function automatic logic [CNT_W-1:0] obfs_step(input logic [CNT_W-1:0] c);
    return (c == {CNT_W{1'b1}}) ? c : c + 32'h1;
  endfunction
endpackage

// File: rtl/obfs_pulse_if.sv
`timescale 1ns/1ps
`default_nettype none
// Fault event into the pulse timer, busy flag back
interface obfs_pulse_if;
  logic faultEvent;   // One-cycle fault request
  logic pulseActive;  // Pin pulse in progress
  modport ctrl (output faultEvent, input pulseActive);
  modport gen  (input faultEvent, output pulseActive);
endinterface
`default_nettype wire

// File: rtl/obfs_fault_pulse.sv
`timescale 1ns/1ps
`default_nettype none
module obfs_fault_pulse
  import obfs_pkg::*;
#(
  parameter logic [31:0] PULSE_CYC = 32'(obfs_pkg::FAULT_PULSE_CYC)
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Event in, busy out
  obfs_pulse_if.gen pif
);
  logic [31:0] cnt_q;   // Remaining cycles
  logic        act_q;   // Pulse in progress
  logic [31:0] lenQ;    // Helper: observed width

  // ************************************************
  // Pulse timer
  // ************************************************
  // Events during a pulse are dropped so pulses never stretch
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_q <= 32'h0;
      act_q <= 1'b0;
    end else if (!act_q && pif.faultEvent) begin
      cnt_q <= PULSE_CYC - 32'h1;
      act_q <= 1'b1;
    end else if (act_q) begin
      if (cnt_q == 32'h0) begin
        act_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q - 32'h1;
      end
    end
  end
  assign pif.pulseActive = act_q;

  // Width observer
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lenQ <= 32'h0;
    end else begin
      lenQ <= act_q ? lenQ + 32'h1 : 32'h0;
    end
  end

  AST_PULSE_WIDTH: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(act_q) |-> lenQ == PULSE_CYC)
    else $error("fault pulse width wrong");
  AST_PULSE_START: assert property (@(posedge clk_sys) disable iff (rst)
    (!act_q && pif.faultEvent) |=> act_q)
    else $error("fault event lost");
endmodule // obfs_fault_pulse
`default_nettype wire

// File: rtl/obfs_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module obfs_ctrl #(
  parameter logic [31:0] FAULT_PULSE_CYC_P = 32'(obfs_pkg::FAULT_PULSE_CYC),
  parameter logic [31:0] SOFTSTART_CYC_P   = 32'(obfs_pkg::SOFTSTART_CYC),
  parameter logic [31:0] OVERLOAD_CYC_P    = 32'(obfs_pkg::OVERLOAD_CYC),
  parameter logic [31:0] WATCHDOG_CYC_P    = 32'(obfs_pkg::WATCHDOG_CYC),
  parameter logic [31:0] OVP_DEGLITCH_P    = 32'(obfs_pkg::OVP_DEGLITCH_CYC)
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Host control bits
  input  wire logic       hostMode,
  input  wire logic       boostReqWr,
  input  wire logic       boostReqWrData,
  input  wire logic       watchdogKick,
  input  wire logic       indicatorDriveAllow,
  input  wire logic       currentLimitHighSel,
  input  wire logic       faultClear,
  // Charger status
  input  wire logic       chargeInProgress,
  input  wire logic       chargeDone,
  input  wire logic       chargeEnable,
  input  wire logic       chargeFaultEvent,
  input  wire logic [2:0] chargeFaultCode,
  // Analog indications
  input  wire logic       chipDisablePin,
  input  wire logic       dieShutdownTemp,
  input  wire logic       dieRegTemp,
  input  wire logic       dieRegTempPlus10,
  input  wire logic       batStartWindow,
  input  wire logic       batAboveHold,
  input  wire logic       batBelowMinimum,
  input  wire logic       inputBelowUvlo,
  input  wire logic       inputAboveBatMinus1V,
  input  wire logic       inputOvervoltage,
  input  wire logic       cycleLimitActive,
  input  wire logic       atMinDuty,
  input  wire logic       outAboveBurstEntry,
  input  wire logic       outBelowBurstExit,
  // Open-drain status and alert pins
  output logic            statusPinOut,
  output logic            statusPinOe,
  output logic            alertPinOut,
  output logic            alertPinOe,
  // Power stage controls
  output logic            buckOn,
  output logic            batterySwitchOn,
  output logic            extBatterySwitchGateOn,
  output logic            linearPrecharge,
  output logic            boostSwitching,
  output logic            boostPwmTick,
  output logic            currentLimitHigh,
  output logic            inputCurrentReduce,
  output logic            inputCurrentZero,
  output logic            timersFrozen,
  output logic            hizMode,
  // Status back to host
  output logic            boostRequest,
  output logic            watchdogExpired,
  output logic [1:0]      stateCode,
  output logic [2:0]      faultCode
);
  import obfs_pkg::*;

  // ************************************************
  // Declarations
  // ************************************************
  obfs_boost_t      bst_q, bst_d;      // Boost state
  logic             tsdQ;              // Shutdown seen last cycle
  logic             tsdRise;           // Shutdown entry event
  logic             boostReq_q;        // Boost request bit
  logic [CNT_W-1:0] ssCnt_q;           // Pre-charge timer
  logic [CNT_W-1:0] ovlCnt_q;          // Overload timer
  logic [CNT_W-1:0] ovpCnt_q;          // Overvoltage deglitch
  logic [CNT_W-1:0] wdCnt_q;           // Watchdog timer
  logic [7:0]       pwmDiv_q;          // Switching divider
  logic             boostOn;           // Any boost state
  logic             entryOk;           // Entry conditions met
  logic             exitCd, exitOvp, exitBat, exitSs, exitOvl;
  logic             wdExpire;          // Watchdog runs out
  logic             hwClear;           // Hardware clears request
  logic             boostFault;        // Boost fault event
  logic             statusLow;         // Steady status drive
  logic [2:0]       faultCode_d;       // Next fault code
  obfs_pulse_if     pif ();

  // ************************************************
  // Fault pulse timer
  // ************************************************
  obfs_fault_pulse #(
    .PULSE_CYC (FAULT_PULSE_CYC_P)
  ) u_pulse (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pif     (pif.gen)
  );

  // ************************************************
  // Thermal protection
  // ************************************************
  // Hysteresis lives in the comparator; here the level is used as is and its rising edge starts a fault pulse
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tsdQ <= 1'b0;
    end else begin
      tsdQ <= dieShutdownTemp;
    end
  end
  assign tsdRise = dieShutdownTemp && !tsdQ;

  // Thermal regulation of input current
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      inputCurrentReduce <= 1'b0;
      inputCurrentZero   <= 1'b0;
      timersFrozen       <= 1'b0;
    end else begin
      inputCurrentReduce <= dieRegTemp || dieRegTempPlus10;
      inputCurrentZero   <= dieRegTempPlus10;
      timersFrozen       <= dieShutdownTemp;
    end
  end

  // ************************************************
  // Boost request bit
  // ************************************************
  assign boostOn = (bst_q != BST_IDLE);
  assign exitCd  = boostOn && chipDisablePin;
  assign exitOvp = boostOn && inputOvervoltage && ovpCnt_q >= OVP_DEGLITCH_P - 32'h1;
  assign exitBat = boostOn && (batBelowMinimum || !batAboveHold);
  assign exitSs  = (bst_q == BST_PRECHG) && !inputAboveBatMinus1V && !tsdQ
                   && ssCnt_q >= SOFTSTART_CYC_P - 32'h1;
  assign exitOvl = (bst_q == BST_SWITCH || bst_q == BST_BURST) && cycleLimitActive
                   && ovlCnt_q >= OVERLOAD_CYC_P - 32'h1;
  assign wdExpire = hostMode && !watchdogKick && !tsdQ
                    && wdCnt_q >= WATCHDOG_CYC_P - 32'h1;
  assign hwClear    = exitCd || exitOvp || exitBat || exitSs || exitOvl || wdExpire;
  assign boostFault = exitOvp || exitBat || exitSs || exitOvl || wdExpire;

  // A host write in the same cycle as a hardware clear wins
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      boostReq_q <= BOOST_REQ_RST;
    end else if (boostReqWr) begin
      boostReq_q <= boostReqWrData;
    end else if (hwClear) begin
      boostReq_q <= 1'b0;
    end
  end
  assign boostRequest = boostReq_q;

  // ************************************************
  // Boost mode state machine
  // ************************************************
  assign entryOk = boostReq_q && hostMode && !chipDisablePin
                   && inputBelowUvlo
                   && batStartWindow && !tsdQ;

  always_comb begin
    bst_d = bst_q;
    if (boostOn && (hwClear || tsdQ || !boostReq_q)) begin
      bst_d = BST_IDLE;
    end else begin
      unique case (bst_q)
        BST_IDLE: begin
          if (entryOk) bst_d = BST_PRECHG;
        end
        BST_PRECHG: begin
          if (inputAboveBatMinus1V) bst_d = BST_SWITCH;
        end
        BST_SWITCH: begin
          if (atMinDuty && outAboveBurstEntry) bst_d = BST_BURST;
        end
        BST_BURST: begin
          if (outBelowBurstExit) bst_d = BST_SWITCH;
        end
        default: bst_d = BST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bst_q <= BST_IDLE;
    end else begin
      bst_q <= bst_d;
    end
  end

  // ************************************************
  // Hold timers
  // ************************************************
  // Each counter restarts as soon as its condition drops
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ssCnt_q <= '0;
    end else if (bst_q == BST_PRECHG && !inputAboveBatMinus1V) begin
      if (!tsdQ) ssCnt_q <= obfs_step(ssCnt_q);
    end else begin
      ssCnt_q <= '0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ovlCnt_q <= '0;
    end else if ((bst_q == BST_SWITCH || bst_q == BST_BURST) && cycleLimitActive) begin
      ovlCnt_q <= obfs_step(ovlCnt_q);
    end else begin
      ovlCnt_q <= '0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ovpCnt_q <= '0;
    end else if (boostOn && inputOvervoltage) begin
      ovpCnt_q <= obfs_step(ovpCnt_q);
    end else begin
      ovpCnt_q <= '0;
    end
  end

  // Watchdog keeps running in boost; frozen in thermal shutdown
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wdCnt_q <= '0;
    end else if (!hostMode || watchdogKick || wdExpire) begin
      wdCnt_q <= '0;
    end else if (!tsdQ) begin
      wdCnt_q <= obfs_step(wdCnt_q);
    end
  end

  // ************************************************
  // Switching clock enable
  // ************************************************
  // Divider only runs while the converter switches
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pwmDiv_q     <= 8'h0;
      boostPwmTick <= 1'b0;
    end else if (bst_q == BST_SWITCH) begin
      boostPwmTick <= (pwmDiv_q == 8'(BOOST_SW_DIV - 1));
      pwmDiv_q     <= (pwmDiv_q == 8'(BOOST_SW_DIV - 1)) ? 8'h0 : pwmDiv_q + 8'h1;
    end else begin
      pwmDiv_q     <= 8'h0;
      boostPwmTick <= 1'b0;
    end
  end

  // ************************************************
  // Power stage outputs
  // ************************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      buckOn                 <= 1'b0;
      batterySwitchOn        <= 1'b0;
      extBatterySwitchGateOn <= 1'b0;
      linearPrecharge        <= 1'b0;
      boostSwitching         <= 1'b0;
      currentLimitHigh       <= 1'b0;
      hizMode                <= 1'b0;
    end else begin
      buckOn <= chargeEnable && !chipDisablePin && !dieShutdownTemp
                && !boostOn;
      batterySwitchOn        <= chipDisablePin || boostOn || chargeInProgress;
      extBatterySwitchGateOn <= chipDisablePin || boostOn;
      linearPrecharge        <= (bst_d == BST_PRECHG);
      boostSwitching         <= (bst_d == BST_SWITCH);
      currentLimitHigh       <= currentLimitHighSel;
      hizMode                <= chipDisablePin;
    end
  end

  // ************************************************
  // Fault events and status
  // ************************************************
  assign pif.faultEvent = tsdRise || chargeFaultEvent || boostFault;

  // Priority: thermal, low supply, overvoltage, overcurrent
  always_comb begin
    faultCode_d = faultCode;
    if (faultClear) faultCode_d = FLT_NONE;
    if (tsdRise) begin
      faultCode_d = FLT_THERMAL;
    end else if (exitBat || wdExpire) begin
      faultCode_d = FLT_LOW_SUP;
    end else if (exitOvp) begin
      faultCode_d = FLT_BST_OVP;
    end else if (exitSs || exitOvl) begin
      faultCode_d = FLT_BST_OC;
    end else if (chargeFaultEvent) begin
      faultCode_d = chargeFaultCode;
    end
  end

  // New faults win over a clear in the same cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      faultCode       <= FLT_NONE;
      stateCode       <= ST_READY;
      watchdogExpired <= 1'b0;
    end else begin
      faultCode       <= faultCode_d;
      watchdogExpired <= wdExpire;
      if (dieShutdownTemp || faultCode_d != FLT_NONE) stateCode <= ST_FAULT;
      else if (chargeInProgress) stateCode <= ST_CHG;
      else if (chargeDone) stateCode <= ST_DONE;
      else stateCode <= ST_READY;
    end
  end

  // ************************************************
  // Status and alert pins
  // ************************************************
  // Steady drive is suppressed in boost and thermal shutdown
  assign statusLow = chargeInProgress && indicatorDriveAllow && !boostOn
                     && !dieShutdownTemp;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      statusPinOe <= 1'b0;
      alertPinOe  <= 1'b0;
    end else begin
      statusPinOe <= pif.pulseActive || statusLow;
      alertPinOe  <= pif.pulseActive || statusLow;
    end
  end
  assign statusPinOut = 1'b0;
  assign alertPinOut  = 1'b0;

  // ************************************************
  // Checks
  // ************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_TSD_STOP: assert property (dieShutdownTemp |=> !buckOn && timersFrozen)
    else $error("buck not off in thermal shutdown");
  AST_TSD_PULSE: assert property (tsdRise && !pif.pulseActive |=> ##1 statusPinOe)
    else $error("no pulse on thermal shutdown");
  AST_STAT_LOW: assert property (statusLow |=> statusPinOe && alertPinOe)
    else $error("status not driven while charging");
  AST_STAT_HIZ: assert property (!pif.pulseActive && !statusLow |=> !statusPinOe)
    else $error("status driven without cause");
  AST_CD_CLEAR: assert property (boostOn && chipDisablePin && !boostReqWr
    |=> !boostRequest && bst_q == BST_IDLE)
    else $error("chip disable did not end boost");
  AST_CD_FETS: assert property (chipDisablePin |=> extBatterySwitchGateOn
    && batterySwitchOn && !buckOn)
    else $error("chip disable stage wrong");
  AST_INPUT_UNDERVOLTAGE_LOCKOUT: assert property (bst_q == BST_IDLE && !inputBelowUvlo |=> bst_q == BST_IDLE)
    else $error("boost entered above lockout");
  AST_SS_TO: assert property (exitSs && !boostReqWr
    |=> !boostRequest && (faultCode == FLT_BST_OC || faultCode == FLT_THERMAL
        || faultCode == FLT_LOW_SUP || faultCode == FLT_BST_OVP))
    else $error("pre-charge timeout missed");
  AST_OVL: assert property (exitOvl |=> bst_q == BST_IDLE ##1 !boostSwitching)
    else $error("overload did not stop boost");
  AST_WD_LOW: assert property (wdExpire && !tsdRise |=> faultCode == FLT_LOW_SUP)
    else $error("watchdog code not low supply");
  AST_BOOST_HIZ: assert property (boostOn && !pif.pulseActive |=> !statusPinOe)
    else $error("status driven in boost");

  COV_BOOST_SW: cover property (bst_q == BST_PRECHG ##1 bst_q == BST_SWITCH);
  COV_BURST: cover property (bst_q == BST_BURST ##[1:20] bst_q == BST_SWITCH);
  COV_OVL: cover property (exitOvl);
  COV_TSD: cover property (tsdRise ##[1:20] !dieShutdownTemp);
endmodule // obfs_ctrl
`default_nettype wire

// File: verification/obfs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host side: writes control bits, kicks the watchdog, times pin pulses
module obfs_host_model (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Status pin after its pull-up
  input  wire logic statusPin,
  // Control bits
  output logic      hostMode,
  output logic      boostReqWr,
  output logic      boostReqWrData,
  output logic      watchdogKick,
  output logic      indicatorDriveAllow,
  output logic      currentLimitHighSel,
  output logic      faultClear
);
  logic       kickEn;   // Kicking on or off
  logic [3:0] kickCnt;  // Kick spacing, well inside the watchdog span
  logic [7:0] lowCnt;   // Cycles low so far
  logic [7:0] lastLow;  // Width of the last low stretch
  int         nPulse;   // Low stretches seen
  // Quiet host at power-up
  initial begin
    {hostMode, boostReqWr, boostReqWrData, indicatorDriveAllow} = 4'h0;
    {currentLimitHighSel, faultClear, kickEn} = 3'h0;
  end
  // Periodic kick; stopping it lets the watchdog run out
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      kickCnt      <= 4'h0;
      watchdogKick <= 1'h0;
    end else begin
      kickCnt      <= kickCnt + 4'h1;
      watchdogKick <= kickEn && (kickCnt == 4'h0);
    end
  end
  // Pin watch: the host only sees levels, so widths are counted here
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lowCnt  <= 8'h0;
      lastLow <= 8'h0;
      nPulse  <= 0;
    end else if (!statusPin) begin
      lowCnt <= lowCnt + 8'h1;
    end else if (lowCnt != 8'h0) begin
      lastLow <= lowCnt;
      lowCnt  <= 8'h0;
      nPulse  <= nPulse + 1;
    end
  end
  // Write the boost request bit
  task automatic wr(input logic v);
    @(posedge clk_sys);
    boostReqWr     <= 1'h1;
    boostReqWrData <= v;
    @(posedge clk_sys);
    boostReqWr     <= 1'h0;
  endtask
  // Clear the latched fault code
  task automatic clr();
    @(posedge clk_sys);
    faultClear <= 1'h1;
    @(posedge clk_sys);
    faultClear <= 1'h0;
  endtask
endmodule // obfs_host_model
`default_nettype wire

// File: verification/obfs_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module obfs_ctrl_tb;
  import obfs_pkg::*;
  logic clk_sys, rst, chargeInProgress, chargeDone, chargeEnable, chargeFaultEvent;
  logic chipDisablePin, dieShutdownTemp, dieRegTemp, dieRegTempPlus10, batStartWindow;
  logic batAboveHold, batBelowMinimum, inputBelowUvlo, inputAboveBatMinus1V, inputOvervoltage;
  logic cycleLimitActive, atMinDuty, outAboveBurstEntry, outBelowBurstExit;
  logic [2:0] chargeFaultCode, faultCode;
  logic [1:0] stateCode;
  logic hostMode, boostReqWr, boostReqWrData, watchdogKick, indicatorDriveAllow;
  logic currentLimitHighSel, faultClear, statusPinOut, statusPinOe, alertPinOut, alertPinOe;
  logic buckOn, batterySwitchOn, extBatterySwitchGateOn, linearPrecharge, boostSwitching;
  logic boostPwmTick, currentLimitHigh, inputCurrentReduce, inputCurrentZero, timersFrozen;
  logic hizMode, boostRequest, watchdogExpired;
  wire  statusPin = statusPinOe ? statusPinOut : 1'h1; // Board pull-up
  int   mismatches, nChecks, n0, nWd, nTick;
  // Short counts keep the run brief
  obfs_ctrl #(.FAULT_PULSE_CYC_P(32'h8), .SOFTSTART_CYC_P(32'h14), .OVERLOAD_CYC_P(32'h14),
    .WATCHDOG_CYC_P(32'h32), .OVP_DEGLITCH_P(32'h3)) u_dut (.*);
  obfs_host_model u_host (.*);
  // One-cycle pulses are counted so a check never has to hit them in passing
  always @(posedge clk_sys) begin
    nWd   <= rst ? 0 : nWd + int'(watchdogExpired);
    nTick <= rst ? 0 : nTick + int'(boostPwmTick);
  end
  initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", nChecks, mismatches);
    if (mismatches == 0 && nChecks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // One boost session ended by exit kind k
  task automatic bexit(input int k);
    logic [2:0] ec;
    ec = (k == 0) ? FLT_BST_OVP : (k == 1) ? FLT_LOW_SUP : (k == 2) ? FLT_NONE : FLT_BST_OC;
    u_host.clr();
    u_host.wr(1'h1);
    cyc(4);
    chk(linearPrecharge, 1'h1);
    if (k != 4) begin
      inputAboveBatMinus1V         <= 1'h1;
      u_host.currentLimitHighSel <= k[0];
      cyc(4);
      chk(boostSwitching, 1'h1);
      chk(currentLimitHigh, k[0]);
      chk(statusPinOe, 1'h0);
    end
    // Light load stop and restart
    if (k == 0) begin
      atMinDuty          <= 1'h1;
      outAboveBurstEntry <= 1'h1;
      cyc(4);
      chk(boostSwitching, 1'h0);
      outAboveBurstEntry <= 1'h0;
      outBelowBurstExit  <= 1'h1;
      cyc(4);
      chk(boostSwitching, 1'h1);
      atMinDuty         <= 1'h0;
      outBelowBurstExit <= 1'h0;
      // One switching tick a divider period after switching restarts
      n0 = nTick;
      cyc(BOOST_SW_DIV + 7);
      chk(nTick - n0, 32'h1);
    end
    n0 = u_host.nPulse;
    inputOvervoltage <= (k == 0);
    batBelowMinimum  <= (k == 1);
    chipDisablePin   <= (k == 2);
    cycleLimitActive <= (k == 3);
    cyc(40);
    chk(boostRequest, 1'h0);
    chk(faultCode, ec);
    chk(u_host.nPulse - n0, k != 2);
    if (k == 2) begin
      chk(hizMode, 1'h1);
    end
    {inputOvervoltage, batBelowMinimum, chipDisablePin, cycleLimitActive} <= 4'h0;
    cyc(20);
    chk(linearPrecharge | boostSwitching, 1'h0);
    inputAboveBatMinus1V <= 1'h0;
    $display("test boost exit %0d done", k);
  endtask
  // Watchdog: a hang counts as a failure
  initial begin
    repeat (3000) @(posedge clk_sys);
    mismatches++;
    results();
  end
  initial begin
    {chargeInProgress, chargeDone, chargeEnable, chargeFaultEvent, chipDisablePin,
     dieShutdownTemp, dieRegTemp, dieRegTempPlus10, batStartWindow, batAboveHold,
     batBelowMinimum, inputBelowUvlo, inputAboveBatMinus1V, inputOvervoltage,
     cycleLimitActive, atMinDuty, outAboveBurstEntry, outBelowBurstExit} = '0;
    chargeFaultCode = 3'h0;
    rst = 1'h1;
    mismatches = 0;
    nChecks = 0;
    cyc(3);
    rst <= 1'h0;
    cyc(2);
    chk(boostRequest, BOOST_REQ_RST);
    chk(faultCode, FLT_NONE);
    {batStartWindow, batAboveHold, inputBelowUvlo} <= 3'h7;
    u_host.hostMode <= 1'h1;
    u_host.kickEn   <= 1'h1;
    // Steady indication, then a doubled fault with drive disallowed
    {chargeEnable, chargeInProgress} <= 2'h3;
    u_host.indicatorDriveAllow <= 1'h1;
    cyc(4);
    chk(statusPinOe, 1'h1);
    chk(alertPinOe, 1'h1);
    chk({statusPinOut, alertPinOut}, 2'h0);
    chk(stateCode, ST_CHG);
    u_host.indicatorDriveAllow <= 1'h0;
    cyc(4);
    chk(statusPinOe, 1'h0);
    chk(alertPinOe, 1'h0);
    n0 = u_host.nPulse;
    chargeFaultCode  <= 3'h5;
    chargeFaultEvent <= 1'h1;
    cyc(1);
    chargeFaultEvent <= 1'h0;
    cyc(3);
    chargeFaultEvent <= 1'h1;
    cyc(1);
    chargeFaultEvent <= 1'h0;
    cyc(20);
    chk(u_host.lastLow, 8'h8);
    chk(u_host.nPulse - n0, 1'h1);
    chk(stateCode, ST_FAULT);
    $display("test charge status done");
    // Thermal steps up to shutdown and back
    u_host.clr();
    dieRegTemp <= 1'h1;
    cyc(4);
    chk(inputCurrentReduce, 1'h1);
    dieRegTempPlus10 <= 1'h1;
    cyc(4);
    chk(inputCurrentZero, 1'h1);
    n0 = u_host.nPulse;
    dieShutdownTemp <= 1'h1;
    cyc(4);
    chk(buckOn, 1'h0);
    chk(timersFrozen, 1'h1);
    cyc(16);
    chk(faultCode, FLT_THERMAL);
    chk(u_host.lastLow, 8'h8);
    chk(u_host.nPulse - n0, 1'h1);
    {dieShutdownTemp, dieRegTemp, dieRegTempPlus10} <= 3'h0;
    cyc(4);
    chk(timersFrozen, 1'h0);
    chk(buckOn, 1'h1);
    // Charge done with drive allowed still floats the pins
    chargeInProgress <= 1'h0;
    chargeDone       <= 1'h1;
    u_host.indicatorDriveAllow <= 1'h1;
    u_host.clr();
    cyc(2);
    chk(stateCode, ST_DONE);
    chk(statusPinOe | alertPinOe, 1'h0);
    chargeDone <= 1'h0;
    $display("test thermal done");
    // Each missing entry condition except thermal shutdown refuses boost
    for (int i = 0; i < 4; i++) begin
      inputBelowUvlo <= (i != 0);
      batStartWindow <= (i != 1);
      chipDisablePin <= (i == 2);
      u_host.hostMode <= (i != 3);
      u_host.wr(1'h1);
      cyc(6);
      chk(linearPrecharge, 1'h0);
      if (i == 2) begin
        chk({buckOn, batterySwitchOn, extBatterySwitchGateOn}, 3'h3);
      end
      u_host.wr(1'h0);
      cyc(2);
    end
    {inputBelowUvlo, batStartWindow, chipDisablePin} <= 3'h6;
    u_host.hostMode <= 1'h1;
    $display("test boost refusal done");
    for (int k = 0; k < 5; k++) begin
      bexit(k);
    end
    // Host stops kicking while boosting
    u_host.clr();
    inputAboveBatMinus1V <= 1'h1;
    n0 = u_host.nPulse;
    u_host.wr(1'h1);
    u_host.kickEn <= 1'h0;
    cyc(80);
    chk(boostRequest, 1'h0);
    chk(faultCode, FLT_LOW_SUP);
    chk(u_host.nPulse - n0, 1'h1);
    chk(nWd, 32'h1);
    $display("test watchdog done");
    results();
  end
endmodule // obfs_ctrl_tb
`default_nettype wire
